// ==== heat_cool_pkg.sv ====
// Purpose: Shared constants for the heat-cool mode selector
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes:   Levels and offset are in tenths of a percent; cooling band percent is whole percent
package heat_cool_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BAND_OFS = 8'h04;
   localparam logic [7:0] TIME_OFS = 8'h08;
   localparam logic [7:0] TRIM_OFS = 8'h0C;
   localparam logic [7:0] COOL_OFS = 8'h10;
   localparam logic [7:0] SETP_OFS = 8'h14;
   localparam logic [7:0] ALM2_OFS = 8'h18;
   localparam logic [7:0] CYC_OFS  = 8'h1C;
   localparam logic [7:0] STAT_OFS = 8'h20;
   // Control word field positions
   localparam int ACT_BIT = 0;
   localparam int O2F_LSB = 1;
   localparam int O1LIN_BIT = 3;
   localparam int O2LIN_BIT = 4;
   localparam int DEV_BIT = 5;
   localparam int TIMER_BIT = 6;
   localparam int SELF_BIT = 7;
   localparam int AUTO_BIT = 8;
   localparam int MAN_BIT = 9;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] BAND_RST = 32'h0000_00C8;
   localparam logic [31:0] TIME_RST = 32'h0028_00B4;
   localparam logic [31:0] TRIM_RST = 32'h0000_0002;
   localparam logic [31:0] COOL_RST = 32'h0000_0064;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   // Limits
   localparam logic [15:0] OFS_MAX = 16'h03E8;
   localparam logic signed [15:0] GAP_MAX = 16'sh0168;
   localparam logic [9:0] FULL = 10'h3E8;
   localparam logic [17:0] PCT_SCALE = 18'h0_0064;
   // Output 2 assignment
   typedef enum logic [1:0] {O2_NONE = 2'b00, O2_COOL = 2'b01, O2_ALARM = 2'b10} o2fn_t;
   // Alarm 2 functions
   localparam logic [3:0] A2_NULL = 4'h0;
   localparam logic [3:0] A2_HIGH = 4'h1;
   // Control modes
   typedef enum logic [1:0] {MODE_ONOFF = 2'b00, MODE_P = 2'b01, MODE_PID = 2'b10} mode_t;
   // Error codes
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_NULL = 2'h1;
   localparam logic [1:0] ERR_COMBO = 2'h2;
endpackage : heat_cool_pkg

// ==== band_divider.sv ====
// Purpose: Sequential restoring divider for the cooling band scale
// Assumes: Divisor never zero
// Notes:   One quotient bit per clock, W clocks per division
`timescale 1ns/1ps
`default_nettype none
module band_divider #(
   parameter int W = 18
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Request
   input  wire logic         start,
   input  wire logic [W-1:0] dividend,
   input  wire logic [7:0]   divisor,
   // Answer
   output logic             idle,
   output logic             done,
   output logic [W-1:0]     quotient
);
   typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} div_t;
   div_t        st;      // Divider state
   logic [7:0]  rem;     // Partial remainder
   logic [5:0]  cnt;     // Bits left
   wire  [8:0]  trial = {rem, quotient[W-1]};
   wire         fits  = trial >= {1'b0, divisor};
   wire  [8:0]  diff  = trial - {1'b0, divisor};

   // Refuse widths the counter cannot hold
   if (W < 2 || W > 63) begin : g_chk
      $error("band_divider width out of range");
   end

   //////////////////////////////////////////////////////////////////
   // Shift-subtract loop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= DIV_IDLE;
         rem <= 8'h00;
         cnt <= 6'h00;
         quotient <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st)
            DIV_IDLE: begin
               if (start) begin
                  quotient <= dividend;
                  rem <= 8'h00;
                  cnt <= 6'(W);
                  st <= DIV_RUN;
               end
            end
            DIV_RUN: begin
               rem <= fits ? diff[7:0] : trial[7:0];
               quotient <= {quotient[W-2:0], fits};
               cnt <= cnt - 6'h01;
               if (cnt == 6'h01) begin
                  st <= DIV_IDLE;
                  done <= 1'b1;
               end
            end
            default: st <= DIV_IDLE;
         endcase
      end
   end

   assign idle = (st == DIV_IDLE);
endmodule : band_divider
`default_nettype wire

// ==== heat_cool_ctrl.sv ====
// Purpose: Control-mode selection and heat/cool output mapping
// Assumes: pid_demand comes from PID logic on aclk, tenths of percent
// Notes:   pv and set points share one engineering unit
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Output 1 reverse heats, direct cools inversely
// - Zero primary band gives on-off output 1
// - Hysteresis used only when band is zero
// - On-off ignores integral, output 1 cycle, offset, cooling band settings
// - On-off disables manual, tuning, bumpless transfer
// - Zero integral time: P/PD plus manual offset
// - Manual offset held within 0 to 100.0
// - P-only control disables auto and self tuning
// - Linear output 1 ignores cycle time
// - Seven heat-cool combinations, else error
// - Alarm-assigned output 2 is on-off side
// - Switch point from alarm set or deviation
// - Output 2 cooling means PID both sides
// - Cooling band percent kept within 1 to 255
// - Cooling band frozen while tuning runs
// - Gap signed, held within -36.0 to 36.0
// - Negative gap overlaps heating and cooling
// - Positive gap leaves idle zone near set point
// - Dwell timer runs in single-output modes
// - Null alarm 2 function flagged as error
module heat_cool_ctrl
   import heat_cool_pkg::*;
#(
   parameter int DW = 12     // Width of the PID demand
) (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   // AXI4-Lite write response
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // AXI4-Lite read
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Process inputs
   input  wire logic signed [15:0] pv,
   input  wire logic signed [DW-1:0] pid_demand,
   input  wire logic               tuning_busy,
   // Output drive
   output logic                    output1_action_on,
   output logic [9:0]              output1_action_level,
   output logic [15:0]             output1_action_cycle,
   output logic                    output2_function_on,
   output logic [9:0]              output2_function_level,
   output logic [15:0]             output2_function_cycle,
   // Mode and feature status
   output mode_t                   control_mode,
   output logic [1:0]              err_code,
   output logic [3:0]              feature_en,
   output logic                    dwell_run
);
   // Refuse demand widths the arithmetic cannot hold
   if (DW < 11 || DW > 12) begin : g_chk
      $error("heat_cool_ctrl demand width out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Helper functions
   // Merge a write through its byte strobes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      end
      return r;
   endfunction : merge

   // Limit a signed value to 0 .. full scale
   function automatic logic [9:0] clamp10(input logic signed [17:0] v);
      if (v < 0) return 10'h000;
      if (v > $signed({8'h00, FULL})) return FULL;
      return v[9:0];
   endfunction : clamp10

   // Reset value of each register word
   function automatic logic [31:0] rst_val(input int i);
      case (i)
         0: return CTRL_RST;
         1: return BAND_RST;
         2: return TIME_RST;
         3: return TRIM_RST;
         4: return COOL_RST;
         default: return ZERO_RST;
      endcase
   endfunction : rst_val

   ////////////////////////////////////////////////////////////////////
   // Register storage and fields
   logic [31:0] regs [0:7];                      // Setting words
   logic [7:0]  aw_addr;                         // Latched write address
   logic [31:0] w_data;                          // Latched write data
   logic [3:0]  w_strb;                          // Latched strobes
   logic        aw_got;                          // Address held
   logic        w_got;                           // Data held
   logic        onoff1;                          // On-off output 1 state
   logic [9:0]  cool_q;                          // Latest scaled cooling
   logic        hyst_used;                       // Hysteresis in effect
   logic        offset_used;                     // Manual offset in effect

   wire        direct_action  = regs[0][ACT_BIT];
   wire o2fn_t output2_function = o2fn_t'(regs[0][O2F_LSB +: 2]);
   wire        o1_linear      = regs[0][O1LIN_BIT];
   wire        o2_linear      = regs[0][O2LIN_BIT];
   wire        dev_mode       = regs[0][DEV_BIT];
   wire        dwell_timer_function = regs[0][TIMER_BIT];
   wire        self_req       = regs[0][SELF_BIT];
   wire        auto_req       = regs[0][AUTO_BIT];
   wire        manual_req     = regs[0][MAN_BIT];
   wire [15:0] primary_prop_band = regs[1][15:0];
   wire [15:0] primary_integral_time = regs[2][15:0];
   wire [15:0] output1_hysteresis = regs[3][15:0];
   wire [15:0] manual_reset_offset = regs[3][31:16];
   wire [7:0]  cooling_band_percent = regs[4][7:0];
   wire signed [15:0] heat_cool_gap = regs[4][31:16];
   wire signed [15:0] main_set_point = regs[5][15:0];
   wire signed [15:0] alarm2_set_point = regs[5][31:16];
   wire signed [15:0] alarm2_deviation = regs[6][15:0];
   wire [3:0]  alarm2_function = regs[6][19:16];
   wire [15:0] output1_cycle_time = regs[7][15:0];
   wire [15:0] output2_cycle_time = regs[7][31:16];

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        wr_fire  = aw_got && w_got && !bvalid;
   wire [2:0]  wr_idx   = aw_addr[4:2];
   wire        wr_map   = (aw_addr[7:5] == 3'h0) || (aw_addr == STAT_OFS);
   wire        wr_store = wr_fire && aw_addr[7:5] == 3'h0;
   wire [31:0] wr_word  = merge(regs[wr_idx], w_data, w_strb);
   wire        rd_map   = (araddr[7:5] == 3'h0) || (araddr == STAT_OFS);
   wire [31:0] status   = {16'h0000, 3'h0, offset_used, hyst_used, dwell_run,
                           feature_en, err_code, control_mode, output2_function_on, output1_action_on};
   wire [31:0] rd_word  = (araddr == STAT_OFS) ? status :
                          rd_map ? regs[araddr[4:2]] : 32'h0000_0000;

   // Sanitised fields of a write
   wire [15:0] new_ofs  = (wr_word[31:16] > OFS_MAX) ? OFS_MAX : wr_word[31:16];
   wire signed [15:0] wgap = wr_word[31:16];
   wire [15:0] new_gap  = (wgap > GAP_MAX) ? GAP_MAX :
                          (wgap < -GAP_MAX) ? 16'(-GAP_MAX) : wr_word[31:16];
   wire [7:0]  new_cpb  = (tuning_busy || wr_word[7:0] == 8'h00) ?
                          cooling_band_percent : wr_word[7:0];
   wire [31:0] store    = (wr_idx == 3'h3) ? {new_ofs, wr_word[15:0]} :
                          (wr_idx == 3'h4) ? {new_gap, 8'h00, new_cpb} : wr_word;

   ////////////////////////////////////////////////////////////////////
   // Write channel handling, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_got <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_got <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_fire) begin
            // Unmapped answers decode error
            bresp <= wr_map ? 2'h0 : 2'h3;
            bvalid <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Register words take their sanitised value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) regs[i] <= rst_val(i);
      end else if (wr_store) begin
         regs[wr_idx] <= store;
      end
   end

   // Read channel, answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'h0;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_map ? 2'h0 : 2'h3;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mode selection
   wire   band_zero = (primary_prop_band == 16'h0000);
   wire   int_zero  = (primary_integral_time == 16'h0000);
   wire mode_t next_mode = band_zero ? MODE_ONOFF : int_zero ? MODE_P : MODE_PID;
   wire   is_onoff  = (next_mode == MODE_ONOFF);
   wire   is_pid    = (next_mode == MODE_PID);
   // Cooling on output 2 needs PID on both sides
   wire   combo_bad = (output2_function == O2_COOL) && !is_pid;
   wire   null_alm  = (output2_function == O2_ALARM) && alarm2_function == A2_NULL;
   wire [1:0] next_err = null_alm ? ERR_NULL : combo_bad ? ERR_COMBO : ERR_NONE;
   // Manual, auto, self, bumpless
   wire [3:0] next_feat = {!is_onoff, is_pid && self_req, is_pid && auto_req,
                           !is_onoff && manual_req};

   ////////////////////////////////////////////////////////////////////
   // Output 1 arithmetic
   // Direct action inverts the demand
   wire signed [17:0] dem  = direct_action ? -18'(pid_demand) : 18'(pid_demand);
   wire signed [17:0] heat = dem + ((next_mode == MODE_P) ?
                             $signed({2'b00, manual_reset_offset}) : 18'sh0_0000);
   wire signed [16:0] err1 = 17'(main_set_point) - 17'(pv);
   wire signed [16:0] ed1  = direct_action ? -err1 : err1;
   wire signed [16:0] half = $signed({2'b00, output1_hysteresis[15:1]});
   wire next_on1 = (ed1 > half) ? 1'b1 : (ed1 < -half) ? 1'b0 : onoff1;
   wire [9:0] next_lvl1 = is_onoff ? (onoff1 ? FULL : 10'h000) : clamp10(heat);

   ////////////////////////////////////////////////////////////////////
   // Cooling on output 2: gap shifts the cooling start
   wire signed [16:0] cool_need = -17'(pid_demand) - 17'(heat_cool_gap);
   wire [15:0] cool_pos = (cool_need > 0) ? cool_need[15:0] : 16'h0000;
   wire [17:0] dividend = {2'b00, cool_pos} * PCT_SCALE;
   wire        div_idle;
   wire        div_done;
   wire [17:0] div_q;

   band_divider #(.W(18)) u_div (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .start    (div_idle),
      .dividend (dividend),
      .divisor  (cooling_band_percent),
      .idle     (div_idle),
      .done     (div_done),
      .quotient (div_q)
   );

   // Alarm-driven on-off side
   wire signed [16:0] sw_pt = dev_mode ? 17'(main_set_point) + 17'(alarm2_deviation)
                                       : 17'(alarm2_set_point);
   wire alm_hit = (alarm2_function == A2_HIGH) ? (17'(pv) > sw_pt) : (17'(pv) < sw_pt);
   wire [9:0] next_lvl2 = (next_err != ERR_NONE) ? 10'h000 :
                          (output2_function == O2_COOL) ? cool_q :
                          (output2_function == O2_ALARM && alm_hit) ? FULL : 10'h000;

   ////////////////////////////////////////////////////////////////////
   // Control state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         onoff1 <= 1'b0;
         cool_q <= 10'h000;
      end else begin
         onoff1 <= next_on1;
         // Quotient is unsigned; a signed clamp would zero large results
         if (div_done) cool_q <= (div_q > 18'(FULL)) ? FULL : div_q[9:0];
      end
   end

   // Registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output1_action_on <= 1'b0;
         output1_action_level <= 10'h000;
         output1_action_cycle <= 16'h0000;
         output2_function_on <= 1'b0;
         output2_function_level <= 10'h000;
         output2_function_cycle <= 16'h0000;
         control_mode <= MODE_ONOFF;
         err_code <= ERR_NONE;
         feature_en <= 4'h0;
         dwell_run <= 1'b0;
         hyst_used <= 1'b0;
         offset_used <= 1'b0;
      end else begin
         output1_action_on <= next_lvl1 != 10'h000;
         output1_action_level <= next_lvl1;
         output1_action_cycle <= (is_onoff || o1_linear) ? 16'h0000 : output1_cycle_time;
         output2_function_on <= next_lvl2 != 10'h000;
         output2_function_level <= next_lvl2;
         output2_function_cycle <= (output2_function == O2_COOL && !o2_linear) ? output2_cycle_time : 16'h0000;
         control_mode <= next_mode;
         err_code <= next_err;
         feature_en <= next_feat;
         dwell_run <= dwell_timer_function && output2_function == O2_NONE;
         hyst_used <= is_onoff;
         offset_used <= next_mode == MODE_P;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_pending;
      aw_got && w_got && !bvalid;
   endsequence
   sequence wr_answer;
      bvalid && !aw_got && !w_got;
   endsequence

   wr_resp_a: assert property (wr_pending |=> wr_answer)
      else $error("write response missing");
   onoff_mode_a: assert property (band_zero |=> control_mode == MODE_ONOFF)
      else $error("zero band not on-off");
   hyst_hidden_a: assert property (!band_zero |=> !hyst_used)
      else $error("hysteresis used with nonzero band");
   onoff_strip_a: assert property (band_zero |=> output1_action_cycle == 16'h0000 && !offset_used)
      else $error("on-off kept cycle or offset");
   onoff_feat_a: assert property (band_zero |=> feature_en == 4'h0)
      else $error("on-off kept features");
   offset_range_a: assert property (manual_reset_offset <= OFS_MAX)
      else $error("offset over range");
   tune_block_a: assert property (int_zero |=> feature_en[2:1] == 2'b00)
      else $error("tuning allowed in P mode");
   lin_cycle_a: assert property (o1_linear |=> output1_action_cycle == 16'h0000)
      else $error("linear output kept cycle");
   cpb_hold_a: assert property (tuning_busy |=> cooling_band_percent == $past(cooling_band_percent))
      else $error("cooling band changed while tuning");
   cpb_range_a: assert property (cooling_band_percent != 8'h00)
      else $error("cooling band zero");
   gap_range_a: assert property (heat_cool_gap <= GAP_MAX && heat_cool_gap >= -GAP_MAX)
      else $error("gap over range");
   null_alarm_a: assert property (null_alm |=> err_code == ERR_NULL ##0 !output2_function_on)
      else $error("null alarm not flagged");
   combo_a: assert property (combo_bad && !null_alm |=> err_code == ERR_COMBO && !output2_function_on)
      else $error("cool output without PID");
endmodule : heat_cool_ctrl
`default_nettype wire

// ==== test_heat_cool_ctrl.sv ====
// Purpose: Self-checking bench for the heat-cool mode selector
// Assumes: Register map and levels as in the shared package
// Notes:   Levels are tenths of percent; waits are bounded
`timescale 1ns/1ps
`default_nettype none
module test_heat_cool_ctrl
   import heat_cool_pkg::*;
;
   // Clock, reset and bus
   logic aclk = 1'b0, aresetn, awvalid, wvalid, bready, arvalid, rready, tuning_busy;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, feature_en;
   logic awready, wready, bvalid, arready, rvalid, output1_action_on, output2_function_on, dwell_run;
   logic [1:0] bresp, rresp, r, err_code;
   // Process side
   logic signed [15:0] pv;
   logic signed [11:0] pid_demand;
   logic [9:0] output1_action_level, output2_function_level;
   logic [15:0] output1_action_cycle, output2_function_cycle;
   mode_t control_mode;
   int num_errors = 0, check_count = 0, i;
   logic [31:0] rst_tab [5] = '{CTRL_RST, BAND_RST, TIME_RST, TRIM_RST, COOL_RST};
   // Cooling rows: cooling word, demand, output 1 level, output 2 level
   logic [31:0] cw [4] = '{32'h0000_0064, 32'hFFD8_0064, 32'h0028_0064, 32'h0000_00C8};
   logic [11:0] dm [4] = '{12'hED4, 12'h014, 12'hFEC, 12'hED4};
   logic [9:0] e1 [4] = '{10'h000, 10'h014, 10'h000, 10'h000}; // Overlap row
   logic [9:0] e2 [4] = '{10'h12C, 10'h014, 10'h000, 10'h096}; // Idle zone, band 200
   ////////////////////////////////////////////////////////////////////////
   // Clock generator
   always #5 aclk = ~aclk;
   heat_cool_ctrl #(.DW(12)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pv,
      .pid_demand, .tuning_busy, .output1_action_on, .output1_action_level, .output1_action_cycle, .output2_function_on, .output2_function_level, .output2_function_cycle,
      .control_mode, .err_code, .feature_en, .dwell_run);
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic finish_test;
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bus write; address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (n == 50) begin
         num_errors++;
         finish_test();
      end
   endtask : wr
   // Bus read; data and response taken at the answering edge
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) begin
         num_errors++;
         finish_test();
      end
   endtask : rd
   // Let settings reach the outputs, cooling divider included
   task automatic settle;
      repeat (40) @(posedge aclk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, tuning_busy} = '0;
      {awaddr, araddr, wdata, pv, pid_demand} = '0;
      wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then an unmapped address
      for (i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk(d, rst_tab[i]);
      end
      rd(8'h40);
      chk(32'(r), 32'h0000_0003);
      wr(8'h40, 32'h0000_0001);
      chk(32'(r), 32'h0000_0003);
      // On-off heating with all features requested
      wr(CYC_OFS, 32'h0007_0005);
      chk(32'(r), 32'h0000_0000);
      wr(SETP_OFS, 32'h0050_0064);
      pv <= 16'sh0032;
      wr(CTRL_OFS, 32'h0000_0380);
      wr(BAND_OFS, 32'h0000_0000);
      settle();
      chk(32'(control_mode), 32'(MODE_ONOFF));
      chk(32'(feature_en), 32'h0000_0000);
      chk(32'(output1_action_cycle), 32'h0000_0000);
      chk(32'(output1_action_on), 32'h0000_0001);
      rd(STAT_OFS);
      chk(32'(d[11]), 32'h0000_0001);
      chk(32'(r), 32'h0000_0000);
      wr(CTRL_OFS, 32'h0000_0381);
      settle();
      chk(32'(output1_action_on), 32'h0000_0000);
      // Proportional control with manual offset
      wr(TIME_OFS, 32'h0028_0000);
      wr(TRIM_OFS, 32'h0064_0002);
      wr(CTRL_OFS, 32'h0000_0380);
      wr(BAND_OFS, 32'h0000_00C8);
      pid_demand <= 12'sh0C8;
      settle();
      chk(32'(control_mode), 32'(MODE_P));
      chk(32'(output1_action_level), 32'h0000_012C);
      chk(32'(feature_en), 32'h0000_0009);
      chk(32'(output1_action_cycle), 32'h0000_0005);
      rd(STAT_OFS);
      chk(32'(d[12:11]), 32'h0000_0002);
      wr(CTRL_OFS, 32'h0000_0388);
      settle();
      chk(32'(output1_action_cycle), 32'h0000_0000);
      wr(TRIM_OFS, 32'h07D0_0002);
      rd(TRIM_OFS);
      chk(d, 32'h03E8_0002);
      wr(CTRL_OFS, 32'h0000_0382);
      settle();
      chk(32'(err_code), 32'(ERR_COMBO));
      // Output 2 as alarm: null function, process then deviation switching
      wr(CTRL_OFS, 32'h0000_0384);
      settle();
      chk(32'(err_code), 32'(ERR_NULL));
      wr(ALM2_OFS, 32'h0001_0014);
      pv <= 16'sh005A;
      settle();
      chk(32'(err_code), 32'(ERR_NONE));
      chk(32'(output2_function_on), 32'h0000_0001);
      wr(CTRL_OFS, 32'h0000_03A4);
      settle();
      chk(32'(output2_function_on), 32'h0000_0000);
      pv <= 16'sh0082;
      settle();
      chk(32'(output2_function_on), 32'h0000_0001);
      wr(CTRL_OFS, 32'h0000_0040);
      settle();
      chk(32'(dwell_run), 32'h0000_0001);
      // PID on both sides
      wr(TIME_OFS, TIME_RST);
      wr(CTRL_OFS, 32'h0000_0382);
      settle();
      chk(32'(control_mode), 32'(MODE_PID));
      chk(32'(feature_en), 32'h0000_000F);
      chk(32'(output2_function_cycle), 32'h0000_0007);
      for (i = 0; i < 4; i++) begin
         wr(COOL_OFS, cw[i]);
         pid_demand <= dm[i];
         settle();
         chk(32'(output1_action_level), 32'(e1[i]));
         chk(32'(output2_function_level), 32'(e2[i]));
      end
      // Cooling band protection and gap limits
      tuning_busy <= 1'b1;
      wr(COOL_OFS, 32'h0000_0032);
      rd(COOL_OFS);
      chk(d, 32'h0000_00C8);
      tuning_busy <= 1'b0;
      wr(COOL_OFS, 32'h0000_0000);
      rd(COOL_OFS);
      chk(d, 32'h0000_00C8);
      wr(COOL_OFS, 32'h0190_0064);
      rd(COOL_OFS);
      chk(d, 32'h0168_0064);
      wr(COOL_OFS, 32'hFE70_0064);
      rd(COOL_OFS);
      chk(d, 32'hFE98_0064);
      finish_test();
   end
endmodule : test_heat_cool_ctrl
`default_nettype wire
